/* rtl/rx_nco_meter_map.svh */
// register indices, field positions, reset values and counts for the
// receive oscillator, mixer and power meter control block.
// assumes: included by bare name; holds definitions only.
`ifndef RX_NCO_METER_MAP_SVH
`define RX_NCO_METER_MAP_SVH
// register indices; byte address is four times the index
`define IDX_PHASE_HI      10'h178
`define IDX_PHASE_LO      10'h179
`define IDX_MIX_CFG       10'h17a
`define IDX_SYNC_CTRL     10'h17b
`define IDX_INTG_HI       10'h17c
`define IDX_INTG_MID      10'h17d
`define IDX_INTG_LO_SYNC  10'h17e
`define IDX_SYNC_LO       10'h17f
`define IDX_INTV_HI       10'h180
`define IDX_INTV_MID      10'h181
`define IDX_LOCAL_CTRL    10'h1c0
`define IDX_COARSE_RES    10'h1c1
`define IDX_FINE_RES      10'h1c2
`define CFG_COUNT         10
`define CFG_RESET         8'h00
`define LOCAL_RESET       8'h00
// mixer and coarse meter config fields
`define MIX_GAIN_LSB      1
`define MIX_EN_BIT        3
`define COARSE_SEL_LSB    5
// sync control fields
`define OSC_SYNC_REQ_BIT  0
`define OSC_SER_SYNC_BIT  1
`define OSC_SRC_BIT       2
`define OSC_DIS_BIT       3
`define MTR_SYNC_REQ_BIT  4
`define MTR_SER_SYNC_BIT  5
`define MTR_SRC_BIT       6
`define MTR_DIS_BIT       7
// local control fields
`define GLB_DIS_BIT       0
`define READOUT_BIT       1
`define COARSE_MODE_BIT   2
// 8n+3 and 8n+4 addends
`define LEN_ADD           24'h000003
`define DELAY_ADD         12'h004
`endif

/* rtl/rx_nco_meter_pkg.sv */
// types shared by the receive oscillator and power meter control block.
// assumes: compiled before every module that imports it.
package rx_nco_meter_pkg;
	typedef enum logic [1:0] {MTR_IDLE, MTR_DELAY, MTR_RUN} meter_state_t;
	typedef logic [7:0] cfg_byte_t;
endpackage : rx_nco_meter_pkg

/* rtl/sync_route.sv */
// picks the sync source of one receive block and makes one pulse of it.
// assumes: pin_level already passed two flops on pclk; other inputs are
// from logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module sync_route
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// selection
	input  wire logic global_dis,
	input  wire logic block_dis,
	input  wire logic src_serial,
	// sources
	input  wire logic pin_level,
	input  wire logic serial_edge,
	input  wire logic global_pulse,
	// result
	output logic      sync_pulse
);
	logic pin_prev_r;
	logic pin_rise;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pin_prev_r <= 1'b0;
		else
			pin_prev_r <= pin_level;

	assign pin_rise = pin_level & ~pin_prev_r;

	// the global source wins whenever the global disable is clear
	always_comb
		if (!global_dis)
			sync_pulse = global_pulse;
		else if (block_dis)
			sync_pulse = 1'b0;
		else if (src_serial)
			sync_pulse = serial_edge;
		else
			sync_pulse = pin_rise;
endmodule : sync_route
`default_nettype wire

/* rtl/nco_mixer.sv */
// oscillator with phase offset and the fine receive mixer with gain.
// assumes: samples and controls come from logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module nco_mixer
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        enable,
	input  wire logic [31:0] freq,
	input  wire logic [15:0] phase_off,
	input  wire logic [1:0]  gain,
	// samples in
	input  wire logic        in_valid,
	input  wire logic [11:0] in_i,
	input  wire logic [11:0] in_q,
	// samples out
	output logic             out_valid,
	output logic [11:0]      out_i,
	output logic [11:0]      out_q
);
	logic        [31:0] acc_r;
	logic        [15:0] phase;
	logic signed [11:0] sin_v;
	logic signed [11:0] cos_v;
	logic signed [24:0] sum_i;
	logic signed [24:0] sum_q;

	// coarse quarter wave; eight steps keep the table small at the cost
	// of spur level
	function automatic logic signed [11:0] qsin(input logic [4:0] p);
		logic [3:0]  k;
		logic [11:0] t;
		k = p[3] ? 4'h8 - {1'b0, p[2:0]} : {1'b0, p[2:0]};
		case (k)
			4'h0: t = 12'h000;
			4'h1: t = 12'h18f;
			4'h2: t = 12'h30f;
			4'h3: t = 12'h471;
			4'h4: t = 12'h5a7;
			4'h5: t = 12'h6a6;
			4'h6: t = 12'h763;
			4'h7: t = 12'h7d8;
			default: t = 12'h7ff;
		endcase
		qsin = p[4] ? -$signed(t) : $signed(t);
	endfunction : qsin

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			acc_r <= 32'h00000000;
		else if (enable && in_valid)
			acc_r <= acc_r + freq;

	assign phase = acc_r[31:16] + phase_off;
	assign sin_v = qsin(phase[15:11]);
	assign cos_v = qsin(phase[15:11] + 5'h08);

	function automatic logic signed [24:0] scale(
		input logic signed [24:0] s, input logic [1:0] g);
		case (g)
			2'h0: scale = s - (s >>> 2);
			2'h1: scale = s >>> 1;
			default: scale = s;
		endcase
	endfunction : scale

	// downconversion by multiplying with cos minus j sin
	assign sum_i = scale(25'($signed(in_i) * cos_v)
		+ 25'($signed(in_q) * sin_v), gain);
	assign sum_q = scale(25'($signed(in_q) * cos_v)
		- 25'($signed(in_i) * sin_v), gain);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			out_valid <= 1'b0;
			out_i     <= 12'h000;
			out_q     <= 12'h000;
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
			begin
				out_i <= enable ? sum_i[22:11] : in_i;
				out_q <= enable ? sum_q[22:11] : in_q;
			end
		end
endmodule : nco_mixer
`default_nettype wire

/* rtl/rx_nco_meter_ctrl.sv */
// receive oscillator, mixer and power meter control with an apb slave.
// assumes: one clock pclk; samples, frequency word, interval low bits
// and the global sync pulse come from logic on pclk; the sync pin is
// asynchronous.
// Notes on behaviour
// - a 16-bit phase offset is added to the accumulator before sine lookup
// - mixer gain code 0 is -2.5 dB, 1 is -6 dB, 2 and 3 0 dB
// - mixer enable turns on the mixer and its oscillator
// - coarse sample count codes 0..6 give 16..1024, code 7 gives 16
// - coarse result refreshes every N samples, copied only after page write
// - readout mode stops the coarse result from refreshing
// - with sync required, new frequency and offset wait for a sync
// - serial oscillator sync bit rising edge syncs when selected and enabled
// - oscillator source select picks pin or serial bit under global disable
// - oscillator sync disable blocks sync only under global disable
// - with meter sync required, metering starts a delay after sync
// - serial meter sync bit rising edge syncs when selected and enabled
// - meter source select picks pin or serial bit under global disable
// - meter sync disable blocks sync only under global disable
// - fine meter integrates over 8N+3 samples of a 21-bit count
// - fine meter waits 8N+4 cycles after sync, 9-bit count
// - fine measurement interval lasts 8N+3 samples, 21-bit count
// - integration low five bits share a register with sync count top bits
// - with global disable clear, the global sync drives every block
// - oscillator frequency is a signed 32-bit word, lsb fs over 2^32
// - mode bit picks fine linear or coarse decibel measurement
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rx_nco_meter_map.svh"
module rx_nco_meter_ctrl
	import rx_nco_meter_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// settings held outside this page
	input  wire logic [31:0] osc_frequency_word,
	input  wire logic [4:0]  interval_length_low,
	// sync sources
	input  wire logic        sync_pin,
	input  wire logic        global_sync_pulse,
	// receive samples
	input  wire logic        sample_valid,
	input  wire logic [11:0] sample_i,
	input  wire logic [11:0] sample_q,
	// mixed samples
	output logic             mix_valid,
	output logic [11:0]      mix_i,
	output logic [11:0]      mix_q,
	// meter state
	output logic             meter_integrating
);
	cfg_byte_t    cfg_r [`CFG_COUNT];
	cfg_byte_t    local_r;
	logic [9:0]   idx;
	logic [9:0]   cfg_idx;
	logic         in_cfg;
	logic         mapped;
	logic         wr_en;
	logic         setup;
	logic         osc_ser_edge_r;
	logic         mtr_ser_edge_r;
	logic         pin_meta_r;
	logic         pin_sync_r;
	logic         osc_sync;
	logic         mtr_sync;
	logic [31:0]  freq_act_r;
	logic [15:0]  phase_act_r;
	logic [15:0]  phase_reg;
	logic [20:0]  integration_length;
	logic [8:0]   post_sync_delay;
	logic [20:0]  interval_length;
	logic         glb_dis;
	logic         mix_en;
	logic         osc_sync_required;
	logic         meter_sync_required;
	logic         meter_coarse_select;
	logic         readout_mode;
	logic [2:0]   coarse_meter_sample_sel;
	meter_state_t mtr_state_r;
	logic [11:0]  delay_cnt_r;
	logic [23:0]  intv_cnt_r;
	logic [47:0]  fine_acc_r;
	logic [47:0]  fine_res_r;
	logic [10:0]  coarse_cnt_r;
	logic [10:0]  coarse_len;
	logic [33:0]  coarse_acc_r;
	logic [7:0]   coarse_db_r;
	logic [7:0]   coarse_rd_r;
	logic         refresh_ok_r;
	logic [23:0]  power;
	logic [23:0]  intv_len;
	logic [23:0]  intg_len;
	logic         intv_end;
	logic         coarse_end;

	assign idx     = paddr[11:2];
	assign cfg_idx = idx - `IDX_PHASE_HI;
	assign in_cfg  = (idx >= `IDX_PHASE_HI) && (idx <= `IDX_INTV_MID);
	assign mapped  = in_cfg || (idx == `IDX_LOCAL_CTRL)
		|| (idx == `IDX_COARSE_RES) || (idx == `IDX_FINE_RES);
	assign setup   = psel && !penable;
	// zero wait states: every access phase ends at its first edge
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite && mapped;

	assign phase_reg  = {cfg_r[0], cfg_r[1]};
	assign mix_en     = cfg_r[2][`MIX_EN_BIT];
	assign coarse_meter_sample_sel = cfg_r[2][`COARSE_SEL_LSB +: 3];
	assign osc_sync_required   = cfg_r[3][`OSC_SYNC_REQ_BIT];
	assign meter_sync_required = cfg_r[3][`MTR_SYNC_REQ_BIT];
	assign integration_length  = {cfg_r[4], cfg_r[5], cfg_r[6][7:3]};
	assign post_sync_delay     = {cfg_r[6][2:0], cfg_r[7][5:0]};
	assign interval_length     = {cfg_r[8], cfg_r[9], interval_length_low};
	assign glb_dis             = local_r[`GLB_DIS_BIT];
	assign readout_mode        = local_r[`READOUT_BIT];
	assign meter_coarse_select = local_r[`COARSE_MODE_BIT];

	// register writes; the result registers are read only
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			for (int k = 0; k < `CFG_COUNT; k++)
				cfg_r[k] <= `CFG_RESET;
			local_r <= `LOCAL_RESET;
		end
		else if (wr_en)
		begin
			if (in_cfg)
				cfg_r[cfg_idx[3:0]] <= pwdata[7:0];
			else if (idx == `IDX_LOCAL_CTRL)
				local_r <= pwdata[7:0];
		end

	// serial sync edges: new bit set while the stored bit was clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			osc_ser_edge_r <= 1'b0;
			mtr_ser_edge_r <= 1'b0;
		end
		else
		begin
			osc_ser_edge_r <= wr_en && (idx == `IDX_SYNC_CTRL)
				&& pwdata[`OSC_SER_SYNC_BIT]
				&& !cfg_r[3][`OSC_SER_SYNC_BIT];
			mtr_ser_edge_r <= wr_en && (idx == `IDX_SYNC_CTRL)
				&& pwdata[`MTR_SER_SYNC_BIT]
				&& !cfg_r[3][`MTR_SER_SYNC_BIT];
		end

	// read data and error are captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			pslverr <= !mapped;
			if (in_cfg)
				prdata <= {24'h000000, cfg_r[cfg_idx[3:0]]};
			else if (idx == `IDX_LOCAL_CTRL)
				prdata <= {24'h000000, local_r};
			else if (idx == `IDX_COARSE_RES)
				prdata <= {24'h000000, coarse_rd_r};
			else if (idx == `IDX_FINE_RES)
				prdata <= fine_res_r[47:16];
			else
				prdata <= 32'h00000000;
		end

	// sync pin crosses into pclk through two flops
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
		end
		else
		begin
			pin_meta_r <= sync_pin;
			pin_sync_r <= pin_meta_r;
		end

	sync_route u_osc_route
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.global_dis   (glb_dis),
		.block_dis    (cfg_r[3][`OSC_DIS_BIT]),
		.src_serial   (cfg_r[3][`OSC_SRC_BIT]),
		.pin_level    (pin_sync_r),
		.serial_edge  (osc_ser_edge_r),
		.global_pulse (global_sync_pulse),
		.sync_pulse   (osc_sync)
	);

	sync_route u_mtr_route
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.global_dis   (glb_dis),
		.block_dis    (cfg_r[3][`MTR_DIS_BIT]),
		.src_serial   (cfg_r[3][`MTR_SRC_BIT]),
		.pin_level    (pin_sync_r),
		.serial_edge  (mtr_ser_edge_r),
		.global_pulse (global_sync_pulse),
		.sync_pulse   (mtr_sync)
	);

	// applied oscillator words follow the registers, or wait for a sync
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			freq_act_r  <= 32'h00000000;
			phase_act_r <= 16'h0000;
		end
		else if (!osc_sync_required || osc_sync)
		begin
			freq_act_r  <= osc_frequency_word;
			phase_act_r <= phase_reg;
		end

	nco_mixer u_nco_mixer
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.enable    (mix_en),
		.freq      (freq_act_r),
		.phase_off (phase_act_r),
		.gain      (cfg_r[2][`MIX_GAIN_LSB +: 2]),
		.in_valid  (sample_valid),
		.in_i      (sample_i),
		.in_q      (sample_q),
		.out_valid (mix_valid),
		.out_i     (mix_i),
		.out_q     (mix_q)
	);

	// power of the mixed i sample feeds both meters
	assign power    = 24'($signed(mix_i) * $signed(mix_i));
	assign intv_len = {3'h0, interval_length} * 24'h000008
		+ `LEN_ADD;
	assign intg_len = {3'h0, integration_length} * 24'h000008
		+ `LEN_ADD;
	assign intv_end = mix_valid && (intv_cnt_r >= intv_len - 24'h000001);

	always_comb
		case (coarse_meter_sample_sel)
			3'h1: coarse_len = 11'd32;
			3'h2: coarse_len = 11'd64;
			3'h3: coarse_len = 11'd128;
			3'h4: coarse_len = 11'd256;
			3'h5: coarse_len = 11'd512;
			3'h6: coarse_len = 11'd1024;
			default: coarse_len = 11'd16;
		endcase

	assign coarse_end = mix_valid
		&& (coarse_cnt_r >= coarse_len - 11'd1);

	// meter sequencing: wait for sync, delay, then run intervals
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mtr_state_r <= MTR_IDLE;
			delay_cnt_r <= 12'h000;
		end
		else
			case (mtr_state_r)
				MTR_IDLE:
					if (!meter_sync_required)
						mtr_state_r <= MTR_RUN;
					else if (mtr_sync)
					begin
						mtr_state_r <= MTR_DELAY;
						delay_cnt_r <= {post_sync_delay, 3'h0}
							+ `DELAY_ADD - 12'h001;
					end
				MTR_DELAY:
					if (delay_cnt_r == 12'h000)
						mtr_state_r <= MTR_RUN;
					else
						delay_cnt_r <= delay_cnt_r - 12'h001;
				MTR_RUN:
					if (meter_sync_required && mtr_sync)
					begin
						mtr_state_r <= MTR_DELAY;
						delay_cnt_r <= {post_sync_delay, 3'h0}
							+ `DELAY_ADD - 12'h001;
					end
				default:
					mtr_state_r <= MTR_IDLE;
			endcase

	assign meter_integrating = (mtr_state_r == MTR_RUN)
		&& !meter_coarse_select && (intv_cnt_r < intg_len);

	// fine meter: integrate the front of each interval, latch at its end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			intv_cnt_r <= 24'h000000;
			fine_acc_r <= 48'h000000000000;
			fine_res_r <= 48'h000000000000;
		end
		else if (mtr_state_r != MTR_RUN || meter_coarse_select)
		begin
			intv_cnt_r <= 24'h000000;
			fine_acc_r <= 48'h000000000000;
		end
		else if (intv_end)
		begin
			intv_cnt_r <= 24'h000000;
			fine_acc_r <= 48'h000000000000;
			fine_res_r <= fine_acc_r;
		end
		else if (mix_valid)
		begin
			intv_cnt_r <= intv_cnt_r + 24'h000001;
			if (intv_cnt_r < intg_len)
				fine_acc_r <= fine_acc_r + {24'h000000, power};
		end

	// rough decibel scale: three steps per doubling of the sum
	function automatic logic [7:0] to_db(input logic [33:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int b = 0; b < 34; b++)
			if (v[b])
				r = 8'(b * 3);
		to_db = r;
	endfunction : to_db

	// coarse meter recomputes every n samples
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			coarse_cnt_r <= 11'd0;
			coarse_acc_r <= 34'h000000000;
			coarse_db_r  <= 8'h00;
		end
		else if (mtr_state_r != MTR_RUN || !meter_coarse_select)
		begin
			coarse_cnt_r <= 11'd0;
			coarse_acc_r <= 34'h000000000;
		end
		else if (coarse_end)
		begin
			coarse_cnt_r <= 11'd0;
			coarse_acc_r <= 34'h000000000;
			coarse_db_r  <= to_db(coarse_acc_r + 34'(power));
		end
		else if (mix_valid)
		begin
			coarse_cnt_r <= coarse_cnt_r + 11'd1;
			coarse_acc_r <= coarse_acc_r + {10'h000, power};
		end

	// the readable copy moves only once the host has written this page,
	// and freezes in readout mode so a multi-read sees one value
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			refresh_ok_r <= 1'b0;
		else if (wr_en)
			refresh_ok_r <= 1'b1;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			coarse_rd_r <= 8'h00;
		else if (refresh_ok_r && !readout_mode)
			coarse_rd_r <= coarse_db_r;
endmodule : rx_nco_meter_ctrl
`default_nettype wire

/* tb/sample_feed.sv */
// receive sample source standing in for the adc path.
// assumes: controls come from the bench on pclk; idle lines toggle.
`timescale 1ns/100ps
`default_nettype none
module sample_feed
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        run,
	input  wire logic        slow,
	input  wire logic [11:0] level,
	// samples
	output logic             sample_valid,
	output logic [11:0]      sample_i,
	output logic [11:0]      sample_q
);
	logic ph_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ph_r         <= 1'b0;
			sample_valid <= 1'b0;
			sample_i     <= 12'h000;
			sample_q     <= 12'h000;
		end
		else
		begin
			ph_r         <= ~ph_r;
			sample_valid <= run && (!slow || ph_r);
			// idle lines flip so a stale sample never looks valid
			if (run && (!slow || ph_r))
			begin
				sample_i <= level;
				sample_q <= 12'h000;
			end
			else
			begin
				sample_i <= ~sample_i;
				sample_q <= ~sample_q;
			end
		end
endmodule : sample_feed
`default_nettype wire

/* tb/rx_nco_meter_ctrl_assertions.sv */
// port checker for the receive oscillator and meter control block.
// assumes: bound to rx_nco_meter_ctrl; shadows the writable page.
`timescale 1ns/100ps
`default_nettype none
`include "rx_nco_meter_map.svh"
module rx_nco_meter_ctrl_assertions
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// stream and sync
	input wire logic        global_sync_pulse,
	input wire logic        sample_valid,
	input wire logic [11:0] sample_i,
	input wire logic [11:0] sample_q,
	input wire logic        mix_valid,
	input wire logic [11:0] mix_i,
	input wire logic [11:0] mix_q,
	input wire logic        meter_integrating
);
	logic [7:0]  sh_r [0:10];
	logic [11:0] dly_r;
	logic [9:0]  idx;
	logic [3:0]  sl;
	logic        cfg, own, bad, rd, mix_en, qual;
	assign idx = paddr[11:2];
	assign cfg = idx >= `IDX_PHASE_HI && idx <= `IDX_INTV_MID;
	assign own = cfg || idx == `IDX_LOCAL_CTRL;
	assign bad = !cfg && !(idx >= `IDX_LOCAL_CTRL && idx <= `IDX_FINE_RES);
	assign sl = cfg ? 4'(idx - `IDX_PHASE_HI) : 4'ha;
	assign rd = psel && penable && !pwrite;
	assign mix_en = sh_r[2][`MIX_EN_BIT];
	assign qual = global_sync_pulse && !sh_r[10][`GLB_DIS_BIT]
		&& sh_r[3][`MTR_SYNC_REQ_BIT] && !sh_r[10][`COARSE_MODE_BIT];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			for (int k = 0; k < 11; k++)
				sh_r[k] <= `CFG_RESET;
		else if (psel && penable && pwrite && pready && own)
			sh_r[sl] <= pwdata[7:0];
	// one cycle of margin kept for a registered sync route
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			dly_r <= 12'h000;
		else if (qual)
			dly_r <= {sh_r[6][2:0], sh_r[7][5:0], 3'b011};
		else if (dly_r != 12'h000)
			dly_r <= dly_r - 12'h001;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	ready_always_a: assert property (pready)
		else $error("pready low");
	err_unmapped_a: assert property (psel && penable |-> pslverr == bad)
		else $error("pslverr wrong");
	rdata_unmapped_a: assert property (rd && bad |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	rdata_upper_a: assert property (rd && idx != `IDX_FINE_RES
		|-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	cfg_readback_a: assert property (rd && own
		|-> prdata == {24'h0, sh_r[sl]})
		else $error("register readback wrong");
	mix_valid_a: assert property ($past(presetn)
		|-> mix_valid == $past(sample_valid))
		else $error("mix_valid not one cycle after sample");
	bypass_exact_a: assert property (
		$past(presetn) && mix_valid && !$past(mix_en)
		|-> mix_i == $past(sample_i) && mix_q == $past(sample_q))
		else $error("mixer off but samples altered");
	meter_delay_a: assert property (
		dly_r != 12'h000 && $past(dly_r) != 12'h000 |-> !meter_integrating)
		else $error("integrating inside post sync delay");
	cover property (qual);
	cover property ($rose(meter_integrating));
	cover property (rd && bad);
endmodule : rx_nco_meter_ctrl_assertions
bind rx_nco_meter_ctrl rx_nco_meter_ctrl_assertions u_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.global_sync_pulse(global_sync_pulse), .sample_valid(sample_valid),
	.sample_i(sample_i), .sample_q(sample_q), .mix_valid(mix_valid),
	.mix_i(mix_i), .mix_q(mix_q), .meter_integrating(meter_integrating)
);
`default_nettype wire

/* tb/tb_rx_nco_mixer_power_meter_ctrl.sv */
// self-checking bench for the receive oscillator and meter control.
// assumes: sample_feed partner; checker bound from its own file.
`timescale 1ns/100ps
`default_nettype none
`include "rx_nco_meter_map.svh"
module tb_rx_nco_mixer_power_meter_ctrl;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [4:0]  intv_lo = 5'h00;
	logic        sync_pin = 1'b0;
	logic        gsp = 1'b0;
	logic        run = 1'b0;
	logic        slow = 1'b0;
	logic [11:0] level = 12'h000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sample_valid;
	logic [11:0] sample_i;
	logic [11:0] sample_q;
	logic        mix_valid;
	logic [11:0] mix_i;
	logic [11:0] mix_q;
	logic        meter_integrating;
	logic [31:0] q;
	logic        e;
	logic [31:0] x = 32'h41e4;
	logic [9:0]  ix;
	logic [7:0]  b;
	logic [7:0]  lc_t [0:5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
	logic [7:0]  sc_t [0:5] = '{8'h05, 8'h0d, 8'h01, 8'h01, 8'h05, 8'h0d};
	int          ev_t [0:5] = '{0, 0, 0, 1, 0, 2};
	logic [5:0]  ap = 6'b101001;
	int          gn [0:3] = '{3, 2, 4, 4};
	int          err_count = 0;
	int          samples_checked = 0;
	int          lvl, d1, d2, hi, tot, n;
	always #10 pclk = ~pclk;
	rx_nco_meter_ctrl u_rx_nco_meter_ctrl
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.osc_frequency_word(32'h0), .interval_length_low(intv_lo),
		.sync_pin(sync_pin), .global_sync_pulse(gsp),
		.sample_valid(sample_valid), .sample_i(sample_i),
		.sample_q(sample_q), .mix_valid(mix_valid), .mix_i(mix_i),
		.mix_q(mix_q), .meter_integrating(meter_integrating)
	);
	sample_feed u_sample_feed
	(
		.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
		.level(level), .sample_valid(sample_valid),
		.sample_i(sample_i), .sample_q(sample_q)
	);
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic check(input string s, input logic [31:0] xp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== xp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, xp, got);
		end
	endtask : check
	// mixer math is fixed point, so a few lsb of slack are allowed
	task automatic near(input string s, input int xp, input logic [11:0] got);
		int v;
		v = $signed(got);
		samples_checked++;
		if ($isunknown(got) || v > xp + 4 || v < xp - 4)
		begin
			err_count++;
			$display("wrong value %s expected %0d seen %0d", s, xp, v);
		end
	endtask : near
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask : reset_dut
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic settle();
		repeat (12) @(posedge pclk);
		while (mix_valid !== 1'b1)
			@(posedge pclk);
	endtask : settle
	task automatic pulse();
		@(posedge pclk);
		gsp <= 1'b1;
		@(posedge pclk);
		gsp <= 1'b0;
	endtask : pulse
	task automatic delay_to_run(output int d);
		logic lo;
		d = 0;
		lo = 1'b0;
		pulse();
		while (!(lo && meter_integrating === 1'b1))
		begin
			if (meter_integrating !== 1'b1)
				lo = 1'b1;
			@(posedge pclk);
			d++;
		end
	endtask : delay_to_run
	task automatic run_len();
		hi = 0;
		tot = 0;
		while (meter_integrating !== 1'b1)
			@(posedge pclk);
		while (meter_integrating === 1'b1)
			@(posedge pclk);
		do
		begin
			@(posedge pclk);
			tot++;
			if (meter_integrating === 1'b1)
				hi++;
		end
		while (hi == 0 || meter_integrating === 1'b1);
	endtask : run_len
	initial
	begin
		#800000;
		err_count++;
		stop_test();
	end
	initial
	begin
		reset_dut();
		run <= 1'b1;
		for (int k = 0; k < 11; k++)
		begin
			ix = (k < 10) ? `IDX_PHASE_HI + 10'(k) : `IDX_LOCAL_CTRL;
			b = 8'(rnd());
			apb(1'b0, ix, 8'h00);
			check("reset value", 32'h0, q);
			apb(1'b1, ix, b);
			apb(1'b0, ix, 8'h00);
			check("readback", {24'h0, b}, q);
		end
		apb(1'b0, 10'h000, 8'h00);
		check("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, `IDX_COARSE_RES, 8'hff);
		check("read-only error", 32'h0, {31'h0, e});
		reset_dut();
		lvl = 512 + int'(rnd() & 32'hff);
		level <= 12'(lvl);
		for (int g = 0; g < 4; g++)
		begin
			apb(1'b1, `IDX_MIX_CFG, 8'h08 | 8'(g << 1));
			settle();
			near("gain i", lvl * gn[g] / 4, mix_i);
			near("gain q", 0, mix_q);
		end
		apb(1'b1, `IDX_PHASE_HI, 8'h80);
		settle();
		near("phase offset", -lvl, mix_i);
		for (int k = 0; k < 6; k++)
		begin
			reset_dut();
			apb(1'b1, `IDX_MIX_CFG, 8'h0c);
			apb(1'b1, `IDX_LOCAL_CTRL, lc_t[k]);
			apb(1'b1, `IDX_SYNC_CTRL, sc_t[k]);
			apb(1'b1, `IDX_PHASE_HI, 8'h80);
			settle();
			near("held offset", lvl, mix_i);
			if (ev_t[k] == 0)
				apb(1'b1, `IDX_SYNC_CTRL, sc_t[k] | 8'h02);
			else if (ev_t[k] == 1)
				sync_pin <= 1'b1;
			else
				pulse();
			settle();
			sync_pin <= 1'b0;
			near("synced", ap[k] ? -lvl : lvl, mix_i);
		end
		reset_dut();
		intv_lo <= 5'd2;
		apb(1'b1, `IDX_INTG_LO_SYNC, 8'h08);
		run_len();
		check("integration", 8 * 1 + 3, hi);
		check("interval", 8 * 2 + 3, tot);
		apb(1'b0, `IDX_FINE_RES, 8'h00);
		check("fine result", 11 * lvl * lvl >> 16, q);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h10);
		apb(1'b1, `IDX_SYNC_LO, 8'h01);
		delay_to_run(d1);
		apb(1'b1, `IDX_SYNC_LO, 8'h03);
		delay_to_run(d2);
		check("delay step", 8 * 2, d2 - d1);
		check("delay floor", 32'h1, {31'h0, d1 >= 12 && d1 <= 15});
		apb(1'b1, `IDX_LOCAL_CTRL, 8'h01);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h50);
		apb(1'b1, `IDX_SYNC_CTRL, 8'h70);
		delay_to_run(d1);
		check("serial meter sync", d2 - 1, d1);
		// slow pacing doubles the cycles per coarse window
		reset_dut();
		slow <= 1'b1;
		level <= 12'h100;
		apb(1'b1, `IDX_LOCAL_CTRL, 8'h04);
		for (int c = 0; c < 8; c++)
		begin
			n = (c == 7) ? 16 : 16 << c;
			apb(1'b1, `IDX_MIX_CFG, 8'(c << 5));
			repeat (6 * n + 40) @(posedge pclk);
			apb(1'b1, `IDX_MIX_CFG, 8'(c << 5));
			apb(1'b0, `IDX_COARSE_RES, 8'h00);
			check("coarse db", 3 * (16 + $clog2(n)), q);
		end
		apb(1'b1, `IDX_LOCAL_CTRL, 8'h06);
		apb(1'b1, `IDX_MIX_CFG, 8'h20);
		repeat (200) @(posedge pclk);
		apb(1'b1, `IDX_MIX_CFG, 8'h20);
		apb(1'b0, `IDX_COARSE_RES, 8'h00);
		check("readout hold", 3 * 20, q);
		stop_test();
	end
endmodule : tb_rx_nco_mixer_power_meter_ctrl
`default_nettype wire
